// file: logic/gpio_status_pkg.sv
// register map, field positions and reset values of the pin status block
package gpio_status_pkg;
   // register offsets on the internal register port
   localparam logic [7:0] PIN_STATUS_GROUP_TWO_OFS  = 8'h24;
   localparam logic [7:0] STATUS_GROUP_SIX_OFS      = 8'h25;
   localparam logic [7:0] BATTERY_VOLTAGE_OFS       = 8'h26;
   localparam logic [7:0] ANALOG_IN_8_OFS           = 8'h27;
   localparam logic [7:0] REMOTE_TEMP_1_OFS         = 8'h28;
   localparam logic [7:0] REMOTE_2_OR_ANALOG_9_OFS  = 8'h29;
   // reset values
   localparam logic [7:0] PIN_STATUS_RESET          = 8'h00;
   localparam logic [7:0] STATUS_SIX_RESET          = 8'h00;
   localparam logic [7:0] READING_RESET             = 8'h00;
   localparam logic [7:0] UNMAPPED_READ             = 8'h00;
   // widths and counts
   localparam int         REG_WIDTH                 = 8;
   localparam int         PINS_PER_REG              = 8;
   localparam int         PINS_PER_CFG              = 4;
   localparam int         READING_COUNT             = 4;
   // polarity field: bit 1, 3, 5, 7 of a pin config register
   localparam int         POL_FIRST_BIT             = 1;
   localparam int         POL_BIT_STEP              = 2;
   // measurement channel indices
   localparam int         CH_BATTERY                = 0;
   localparam int         CH_ANALOG_IN_8            = 1;
   localparam int         CH_REMOTE_TEMP_1          = 2;
   localparam int         CH_REMOTE_TEMP_2          = 3;
endpackage

// file: logic/gpio_status_readings.sv
// pin status registers for general pins 8..15 and measurement readings
//
// Overview of operation
// - input pin sets its status bit while asserted; pin 8 at bit 0.
// - output pin: writing one asserts the pin, writing zero deasserts it.
// - pins 8 to 11 polarity from bits 1,3,5,7 of config register three.
// - pins 12 to 15 polarity from bits 1,3,5,7 of config register four.
// - status bit writable only while its pin is an output.
// - pin status register at 24h resets to 00h.
// - status register at 25h resets to 00h; same write restriction.
// - read-only 26h holds latest battery voltage reading, resets 00h.
// - read-only 27h holds latest analog input 8 reading, resets 00h.
// - read-only 28h holds latest remote diode 1 temperature, resets 00h.
// - read-only 29h holds remote diode 2 or analog 9, resets 00h.
`timescale 1ns/1ps
module gpio_status_readings
   import gpio_status_pkg::*;
#(
   parameter int PIN_COUNT = 8
) (
   input  wire logic                 I_CLOCK,
   input  wire logic                 I_SYS_RST,
   input  wire logic                 I_CLOCK_EN,
   // internal register port from the serial management interface
   input  wire logic [7:0]           I_REG_ADDR,
   input  wire logic                 I_REG_WR,
   input  wire logic                 I_REG_RD,
   input  wire logic [7:0]           I_REG_WDATA,
   output logic      [7:0]           O_REG_RDATA,
   // pin configuration, direction and group six status sources
   input  wire logic [7:0]           I_PIN_CFG3,
   input  wire logic [7:0]           I_PIN_CFG4,
   input  wire logic [PIN_COUNT-1:0] I_PIN_DIR_OUT,
   input  wire logic [7:0]           I_STAT6_SRC,
   input  wire logic [7:0]           I_STAT6_PIN_MASK,
   // measurement engine results
   input  wire logic [3:0]           I_MEAS_DONE,
   input  wire logic [7:0]           I_MEAS_DATA,
   // general pins 8..15, three signals each
   input  wire logic [PIN_COUNT-1:0] I_GENERAL_PIN,
   output logic      [PIN_COUNT-1:0] O_GENERAL_PIN,
   output logic      [PIN_COUNT-1:0] O_GENERAL_PIN_OE
);
   if (PIN_COUNT != PINS_PER_REG) begin : g_bad_count
      $error("PIN_COUNT must equal the status register width");
   end

   typedef logic [REG_WIDTH-1:0] byte_t;

   // polarity select of one pin out of its config register
   function automatic logic pol_of(input byte_t cfg, input int slot);
      pol_of = cfg[POL_FIRST_BIT + POL_BIT_STEP * slot];
   endfunction

   // register offset match
   function automatic logic hit(input byte_t addr, input byte_t ofs);
      hit = (addr == ofs);
   endfunction

   logic  [PIN_COUNT-1:0] active_high;
   logic  [PIN_COUNT-1:0] asserted;
   byte_t                 pin_status;
   byte_t                 status_six;
   byte_t                 reading [READING_COUNT];
   byte_t                 next_pin_status;
   byte_t                 next_status_six;
   byte_t                 next_reading [READING_COUNT];
   byte_t                 next_rdata;
   logic  [PIN_COUNT-1:0] next_pin;
   logic  [PIN_COUNT-1:0] next_pin_oe;
   logic                  wr_pins;
   logic                  wr_six;

   // polarity per pin and its synchronised sense cell
   for (genvar g = 0; g < PIN_COUNT; g++) begin : g_pin
      if (g < PINS_PER_CFG) begin : g_cfg3
         assign active_high[g] = pol_of(I_PIN_CFG3, g);
      end else begin : g_cfg4
         assign active_high[g] = pol_of(I_PIN_CFG4,
                                        g - PINS_PER_CFG);
      end
      pin_sense_cell u_cell (
         .i_clk         (I_CLOCK),
         .i_rst         (I_SYS_RST),
         .i_en          (I_CLOCK_EN),
         .i_pin         (I_GENERAL_PIN[g]),
         .i_active_high (active_high[g]),
         .o_asserted    (asserted[g])
      );
   end

   assign wr_pins = I_REG_WR && hit(I_REG_ADDR, PIN_STATUS_GROUP_TWO_OFS);
   assign wr_six  = I_REG_WR && hit(I_REG_ADDR, STATUS_GROUP_SIX_OFS);

   // status bits: inputs follow the pin, outputs take host writes
   always_comb begin
      next_pin_status = pin_status;
      for (int i = 0; i < PIN_COUNT; i++) begin
         if (!I_PIN_DIR_OUT[i]) begin
            next_pin_status[i] = asserted[i];
         end else if (wr_pins) begin
            next_pin_status[i] = I_REG_WDATA[i];
         end
      end
   end

   // group six: pin bits writable as outputs, others follow the source
   always_comb begin
      next_status_six = (I_STAT6_SRC & ~I_STAT6_PIN_MASK)
                      | (status_six & I_STAT6_PIN_MASK);
      if (wr_six) begin
         next_status_six = (next_status_six & ~I_STAT6_PIN_MASK)
                         | (I_REG_WDATA & I_STAT6_PIN_MASK);
      end
   end

   // pin drive follows the status bit through the polarity
   always_comb begin
      for (int i = 0; i < PIN_COUNT; i++) begin
         next_pin[i] = I_PIN_DIR_OUT[i]
                     & ~(next_pin_status[i] ^ active_high[i]);
      end
      next_pin_oe = I_PIN_DIR_OUT;
   end

   // readings load only on a completed conversion
   always_comb begin
      for (int c = 0; c < READING_COUNT; c++) begin
         next_reading[c] = I_MEAS_DONE[c] ? I_MEAS_DATA
                                          : reading[c];
      end
   end

   // read data mux, held between reads
   always_comb begin
      next_rdata = O_REG_RDATA;
      if (I_REG_RD) begin
         case (I_REG_ADDR)
            PIN_STATUS_GROUP_TWO_OFS:  next_rdata = pin_status;
            STATUS_GROUP_SIX_OFS:      next_rdata = status_six;
            BATTERY_VOLTAGE_OFS: begin
               next_rdata = reading[CH_BATTERY];
            end
            ANALOG_IN_8_OFS: begin
               next_rdata = reading[CH_ANALOG_IN_8];
            end
            REMOTE_TEMP_1_OFS: begin
               next_rdata = reading[CH_REMOTE_TEMP_1];
            end
            REMOTE_2_OR_ANALOG_9_OFS: begin
               next_rdata = reading[CH_REMOTE_TEMP_2];
            end
            default:                   next_rdata = UNMAPPED_READ;
         endcase
      end
   end

   // state registers, frozen while the clock enable is low
   always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         pin_status       <= PIN_STATUS_RESET;
         status_six       <= STATUS_SIX_RESET;
         for (int c = 0; c < READING_COUNT; c++) begin
            reading[c] <= READING_RESET;
         end
         O_REG_RDATA      <= UNMAPPED_READ;
         O_GENERAL_PIN    <= '0;
         O_GENERAL_PIN_OE <= '0;
      end else if (I_CLOCK_EN) begin
         pin_status       <= next_pin_status;
         status_six       <= next_status_six;
         for (int c = 0; c < READING_COUNT; c++) begin
            reading[c] <= next_reading[c];
         end
         O_REG_RDATA      <= next_rdata;
         O_GENERAL_PIN    <= next_pin;
         O_GENERAL_PIN_OE <= next_pin_oe;
      end
   end

   // checks on the behaviour above
   sequence s_pin_write;
      I_CLOCK_EN && wr_pins;
   endsequence

   sequence s_enabled_step;
      I_CLOCK_EN;
   endsequence

   sequence s_frozen_step;
      !I_CLOCK_EN;
   endsequence

   sequence s_pin_read;
      I_CLOCK_EN && I_REG_RD && (I_REG_ADDR == PIN_STATUS_GROUP_TWO_OFS);
   endsequence

   AST_INPUT_TRACKS: assert property (
      @(posedge I_CLOCK) disable iff (I_SYS_RST)
      s_enabled_step |=> ((pin_status & ~$past(I_PIN_DIR_OUT))
                         == ($past(asserted) & ~$past(I_PIN_DIR_OUT))))
      else $error("input pin status does not follow the pin");

   AST_OUTPUT_WRITE: assert property (
      @(posedge I_CLOCK) disable iff (I_SYS_RST)
      s_pin_write |=> ((pin_status & $past(I_PIN_DIR_OUT))
                      == ($past(I_REG_WDATA) & $past(I_PIN_DIR_OUT))))
      else $error("output pin status missed a host write");

   AST_PIN_DRIVE: assert property (
      @(posedge I_CLOCK) disable iff (I_SYS_RST)
      s_enabled_step |=> (O_GENERAL_PIN == ($past(I_PIN_DIR_OUT)
                         & ~(pin_status ^ $past(active_high)))))
      else $error("pin drive disagrees with status and polarity");

   AST_POL_CFG3: assert property (
      @(posedge I_CLOCK) disable iff (I_SYS_RST)
      active_high[3:0] == {I_PIN_CFG3[7], I_PIN_CFG3[5],
                           I_PIN_CFG3[3], I_PIN_CFG3[1]})
      else $error("pins 8 to 11 polarity mapping wrong");

   AST_POL_CFG4: assert property (
      @(posedge I_CLOCK) disable iff (I_SYS_RST)
      active_high[7:4] == {I_PIN_CFG4[7], I_PIN_CFG4[5],
                           I_PIN_CFG4[3], I_PIN_CFG4[1]})
      else $error("pins 12 to 15 polarity mapping wrong");

   AST_INPUT_NO_WRITE: assert property (
      @(posedge I_CLOCK) disable iff (I_SYS_RST)
      s_pin_write ##1 (I_CLOCK_EN && !wr_pins)
      |-> (pin_status & ~$past(I_PIN_DIR_OUT))
          == ($past(asserted) & ~$past(I_PIN_DIR_OUT)))
      else $error("write reached a pin configured as input");

   AST_SIX_WRITE: assert property (
      @(posedge I_CLOCK) disable iff (I_SYS_RST)
      (I_CLOCK_EN && wr_six) |=> ((status_six & $past(I_STAT6_PIN_MASK))
                    == ($past(I_REG_WDATA) & $past(I_STAT6_PIN_MASK))))
      else $error("group six pin bit missed a write");

   AST_BATTERY_LOAD: assert property (
      @(posedge I_CLOCK) disable iff (I_SYS_RST)
      (I_CLOCK_EN && I_MEAS_DONE[0])
      |=> reading[CH_BATTERY] == $past(I_MEAS_DATA))
      else $error("battery reading not loaded on done");

   AST_READING_HOLD: assert property (
      @(posedge I_CLOCK) disable iff (I_SYS_RST)
      (I_MEAS_DONE == 4'h0) |=> $stable(reading[CH_REMOTE_TEMP_1])
                             && $stable(reading[CH_ANALOG_IN_8]))
      else $error("reading changed without a conversion");

   AST_READ_REMOTE2: assert property (
      @(posedge I_CLOCK) disable iff (I_SYS_RST)
      (I_CLOCK_EN && I_REG_RD && I_REG_ADDR == REMOTE_2_OR_ANALOG_9_OFS)
      |=> O_REG_RDATA == $past(reading[CH_REMOTE_TEMP_2]))
      else $error("remote diode 2 read returned wrong data");

   AST_PIN_HOLD: assert property (
      @(posedge I_CLOCK) disable iff (I_SYS_RST)
      (I_CLOCK_EN && !wr_pins) |=> ((pin_status & $past(I_PIN_DIR_OUT))
                    == ($past(pin_status) & $past(I_PIN_DIR_OUT))))
      else $error("output pin status changed without a write");

   AST_PIN_OE: assert property (
      @(posedge I_CLOCK) disable iff (I_SYS_RST)
      s_enabled_step |=> O_GENERAL_PIN_OE == $past(I_PIN_DIR_OUT))
      else $error("pin output enable does not follow direction");

   AST_SIX_SOURCE: assert property (
      @(posedge I_CLOCK) disable iff (I_SYS_RST)
      s_enabled_step |=> ((status_six & ~$past(I_STAT6_PIN_MASK))
                         == ($past(I_STAT6_SRC) & ~$past(I_STAT6_PIN_MASK))))
      else $error("group six source bit does not follow its source");

   AST_SIX_HOLD: assert property (
      @(posedge I_CLOCK) disable iff (I_SYS_RST)
      (I_CLOCK_EN && !wr_six) |=> ((status_six & $past(I_STAT6_PIN_MASK))
                    == ($past(status_six) & $past(I_STAT6_PIN_MASK))))
      else $error("group six pin bit changed without a write");

   AST_ANALOG8_LOAD: assert property (
      @(posedge I_CLOCK) disable iff (I_SYS_RST)
      (I_CLOCK_EN && I_MEAS_DONE[CH_ANALOG_IN_8])
      |=> reading[CH_ANALOG_IN_8] == $past(I_MEAS_DATA))
      else $error("analog input 8 reading not loaded on done");

   AST_REMOTE1_LOAD: assert property (
      @(posedge I_CLOCK) disable iff (I_SYS_RST)
      (I_CLOCK_EN && I_MEAS_DONE[CH_REMOTE_TEMP_1])
      |=> reading[CH_REMOTE_TEMP_1] == $past(I_MEAS_DATA))
      else $error("remote diode 1 reading not loaded on done");

   AST_REMOTE2_LOAD: assert property (
      @(posedge I_CLOCK) disable iff (I_SYS_RST)
      (I_CLOCK_EN && I_MEAS_DONE[CH_REMOTE_TEMP_2])
      |=> reading[CH_REMOTE_TEMP_2] == $past(I_MEAS_DATA))
      else $error("remote diode 2 reading not loaded on done");

   AST_FROZEN: assert property (
      @(posedge I_CLOCK) disable iff (I_SYS_RST)
      s_frozen_step |=> $stable(reading[CH_BATTERY]) && $stable(pin_status)
                        && $stable(status_six) && $stable(O_REG_RDATA))
      else $error("state moved while the clock enable was low");

   AST_READ_PINS: assert property (
      @(posedge I_CLOCK) disable iff (I_SYS_RST)
      s_pin_read |=> O_REG_RDATA == $past(pin_status))
      else $error("pin status read returned wrong data");

   AST_RDATA_HOLD: assert property (
      @(posedge I_CLOCK) disable iff (I_SYS_RST)
      (I_CLOCK_EN && !I_REG_RD) |=> $stable(O_REG_RDATA))
      else $error("read data changed without a read");
endmodule

// file: logic/pin_sense_cell.sv
// one general pin: two-stage synchroniser and polarity resolve
`timescale 1ns/1ps
module pin_sense_cell (
   input  wire logic i_clk,
   input  wire logic i_rst,
   input  wire logic i_en,
   input  wire logic i_pin,
   input  wire logic i_active_high,
   output logic      o_asserted
);
   logic meta;
   logic sync;
   logic next_meta;
   logic next_sync;

   // shift the raw pin level in
   always_comb begin
      next_meta = i_pin;
      next_sync = meta;
   end

   // synchroniser flops, frozen while disabled
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         meta <= 1'h0;
         sync <= 1'h0;
      end else if (i_en) begin
         meta <= next_meta;
         sync <= next_sync;
      end
   end

   // asserted level depends on the selected polarity
   assign o_asserted = i_active_high ? sync : ~sync;
endmodule

// file: test/tb.sv
// self-checking bench for the pin status and readings block
`timescale 1ns/1ps
`define CHK(nm, ex, ac) begin checks++; if ((ac) !== (ex)) begin \
   miscompares++; \
   $display("MISMATCH %s expected %h seen %h", nm, ex, ac); end end
module tb;
   import gpio_status_pkg::*;
   logic       I_CLOCK = 1'h0;
   logic       I_SYS_RST = 1'h1;
   logic       I_CLOCK_EN = 1'h1;
   logic [7:0] I_REG_ADDR = 8'h00;
   logic       I_REG_WR = 1'h0;
   logic       I_REG_RD = 1'h0;
   logic [7:0] I_REG_WDATA = 8'h00;
   logic [7:0] O_REG_RDATA;
   logic [7:0] I_PIN_CFG3 = 8'haa;
   logic [7:0] I_PIN_CFG4 = 8'haa;
   logic [7:0] I_PIN_DIR_OUT = 8'h00;
   logic [7:0] I_STAT6_SRC = 8'h00;
   logic [7:0] I_STAT6_PIN_MASK = 8'hf0;
   logic [3:0] I_MEAS_DONE = 4'h0;
   logic [7:0] I_MEAS_DATA = 8'h00;
   logic [7:0] I_GENERAL_PIN = 8'h00;
   logic [7:0] O_GENERAL_PIN;
   logic [7:0] O_GENERAL_PIN_OE;
   int         miscompares = 0;
   int         checks = 0;
   gpio_status_readings #(.PIN_COUNT(8)) i_gpio_status_readings (
      .I_CLOCK(I_CLOCK), .I_SYS_RST(I_SYS_RST), .I_CLOCK_EN(I_CLOCK_EN),
      .I_REG_ADDR(I_REG_ADDR), .I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD),
      .I_REG_WDATA(I_REG_WDATA), .O_REG_RDATA(O_REG_RDATA),
      .I_PIN_CFG3(I_PIN_CFG3), .I_PIN_CFG4(I_PIN_CFG4),
      .I_PIN_DIR_OUT(I_PIN_DIR_OUT), .I_STAT6_SRC(I_STAT6_SRC),
      .I_STAT6_PIN_MASK(I_STAT6_PIN_MASK), .I_MEAS_DONE(I_MEAS_DONE),
      .I_MEAS_DATA(I_MEAS_DATA), .I_GENERAL_PIN(I_GENERAL_PIN),
      .O_GENERAL_PIN(O_GENERAL_PIN), .O_GENERAL_PIN_OE(O_GENERAL_PIN_OE));
   // 20 MHz clock
   always #25 I_CLOCK = ~I_CLOCK;
   // one write strobe, driven at the falling edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge I_CLOCK);
      I_REG_ADDR = a;
      I_REG_WDATA = d;
      I_REG_WR = 1'h1;
      @(negedge I_CLOCK);
      I_REG_WR = 1'h0;
   endtask
   // one read strobe, then compare the answer
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] ex);
      @(negedge I_CLOCK);
      I_REG_ADDR = a;
      I_REG_RD = 1'h1;
      @(negedge I_CLOCK);
      I_REG_RD = 1'h0;
      @(negedge I_CLOCK);
      `CHK("read data", ex, O_REG_RDATA)
   endtask
   // one conversion result on the given channels
   task automatic meas(input logic [3:0] ch, input logic [7:0] d);
      @(negedge I_CLOCK);
      I_MEAS_DONE = ch;
      I_MEAS_DATA = d;
      @(negedge I_CLOCK);
      I_MEAS_DONE = 4'h0;
   endtask
   // every register and pin output after reset
   task automatic test_reset;
      rd_chk(PIN_STATUS_GROUP_TWO_OFS, 8'h00);
      rd_chk(STATUS_GROUP_SIX_OFS, 8'h00);
      rd_chk(BATTERY_VOLTAGE_OFS, 8'h00);
      rd_chk(ANALOG_IN_8_OFS, 8'h00);
      rd_chk(REMOTE_TEMP_1_OFS, 8'h00);
      rd_chk(REMOTE_2_OR_ANALOG_9_OFS, 8'h00);
      `CHK("pin oe", 8'h00, O_GENERAL_PIN_OE)
      `CHK("pin level", 8'h00, O_GENERAL_PIN)
      $display("test_reset done");
   endtask
   // inputs sensed with mixed polarity; writes to input bits ignored
   task automatic test_inputs;
      @(negedge I_CLOCK);
      I_GENERAL_PIN = 8'h35;
      I_PIN_CFG4 = 8'h00;
      repeat (5) @(negedge I_CLOCK);
      rd_chk(PIN_STATUS_GROUP_TWO_OFS, 8'hc5);
      wr(PIN_STATUS_GROUP_TWO_OFS, 8'h3a);
      rd_chk(PIN_STATUS_GROUP_TWO_OFS, 8'hc5);
      $display("test_inputs done");
   endtask
   // low pins driven, polarity flip, deassert by zero
   task automatic test_outputs;
      @(negedge I_CLOCK);
      I_PIN_DIR_OUT = 8'h0f;
      wr(PIN_STATUS_GROUP_TWO_OFS, 8'h0a);
      repeat (2) @(negedge I_CLOCK);
      `CHK("pin oe", 8'h0f, O_GENERAL_PIN_OE)
      `CHK("pin level", 8'h0a, O_GENERAL_PIN)
      rd_chk(PIN_STATUS_GROUP_TWO_OFS, 8'hca);
      I_PIN_CFG3 = 8'h00;
      repeat (2) @(negedge I_CLOCK);
      `CHK("pin level", 8'h05, O_GENERAL_PIN)
      wr(PIN_STATUS_GROUP_TWO_OFS, 8'h00);
      repeat (2) @(negedge I_CLOCK);
      `CHK("pin level", 8'h0f, O_GENERAL_PIN)
      rd_chk(PIN_STATUS_GROUP_TWO_OFS, 8'hc0);
      $display("test_outputs done");
   endtask
   // second status register: source bits read-only, pin bits writable
   task automatic test_status_six;
      @(negedge I_CLOCK);
      I_STAT6_SRC = 8'h05;
      rd_chk(STATUS_GROUP_SIX_OFS, 8'h05);
      wr(STATUS_GROUP_SIX_OFS, 8'h9a);
      rd_chk(STATUS_GROUP_SIX_OFS, 8'h95);
      $display("test_status_six done");
   endtask
   // readings load on done only, ignore writes and frozen edges
   task automatic test_readings;
      meas(4'h1, 8'h10);
      rd_chk(BATTERY_VOLTAGE_OFS, 8'h10);
      meas(4'h2, 8'h11);
      rd_chk(ANALOG_IN_8_OFS, 8'h11);
      meas(4'h4, 8'h12);
      rd_chk(REMOTE_TEMP_1_OFS, 8'h12);
      meas(4'h8, 8'h13);
      rd_chk(REMOTE_2_OR_ANALOG_9_OFS, 8'h13);
      wr(BATTERY_VOLTAGE_OFS, 8'hff);
      rd_chk(BATTERY_VOLTAGE_OFS, 8'h10);
      rd_chk(BATTERY_VOLTAGE_OFS, 8'h10);
      wr(REMOTE_2_OR_ANALOG_9_OFS, 8'hff);
      rd_chk(REMOTE_2_OR_ANALOG_9_OFS, 8'h13);
      @(negedge I_CLOCK);
      I_CLOCK_EN = 1'h0;
      meas(4'h1, 8'h77);
      I_CLOCK_EN = 1'h1;
      rd_chk(BATTERY_VOLTAGE_OFS, 8'h10);
      meas(4'h3, 8'h5a);
      rd_chk(BATTERY_VOLTAGE_OFS, 8'h5a);
      rd_chk(ANALOG_IN_8_OFS, 8'h5a);
      rd_chk(REMOTE_TEMP_1_OFS, 8'h12);
      rd_chk(8'h2a, UNMAPPED_READ);
      $display("test_readings done");
   endtask
   // reset in mid run clears every register and pin output
   task automatic test_mid_reset;
      wr(PIN_STATUS_GROUP_TWO_OFS, 8'h05);
      rd_chk(REMOTE_TEMP_1_OFS, 8'h12);
      @(negedge I_CLOCK);
      I_SYS_RST = 1'h1;
      I_STAT6_SRC = 8'h00;
      repeat (2) @(negedge I_CLOCK);
      `CHK("reset read data", 8'h00, O_REG_RDATA)
      `CHK("reset pin level", 8'h00, O_GENERAL_PIN)
      `CHK("reset pin oe", 8'h00, O_GENERAL_PIN_OE)
      I_SYS_RST = 1'h0;
      rd_chk(STATUS_GROUP_SIX_OFS, 8'h00);
      rd_chk(BATTERY_VOLTAGE_OFS, 8'h00);
      rd_chk(ANALOG_IN_8_OFS, 8'h00);
      rd_chk(REMOTE_TEMP_1_OFS, 8'h00);
      rd_chk(REMOTE_2_OR_ANALOG_9_OFS, 8'h00);
      rd_chk(PIN_STATUS_GROUP_TWO_OFS, 8'hc0);
      $display("test_mid_reset done");
   endtask
   // verdict and end of run
   task automatic report_and_stop;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // cut a hang short
   initial begin
      repeat (20000) @(posedge I_CLOCK);
      miscompares++;
      report_and_stop();
   end
   // main sequence
   initial begin
      repeat (16) @(negedge I_CLOCK);
      I_SYS_RST = 1'h0;
      test_reset();
      test_inputs();
      test_outputs();
      test_status_six();
      test_readings();
      test_mid_reset();
      report_and_stop();
   end
endmodule
